// ==== design/tap_abort_classify.sv ====
// builds the abort information word from cause and region cycles
`include "tap_params.svh"
module tap_abort_classify (
	input  wire tap_pkg::tap_cause_t     i_cause,
	input  wire logic [`TAP_CYC_W-1:0]   i_cycles,
	output logic [`TAP_INFO_W-1:0]       o_info
);

	logic is_instr;
	logic is_conflict;
	logic is_cap_wr;
	logic is_cap_rd;

	// exceptions and explicit aborts belong to an instruction
	assign is_instr    = (i_cause == tap_pkg::TAP_CAUSE_INSTR)
		| (i_cause == tap_pkg::TAP_CAUSE_EXCEPTION)                     // see RULE8
		| (i_cause == tap_pkg::TAP_CAUSE_EXPLICIT);
	assign is_conflict = (i_cause == tap_pkg::TAP_CAUSE_CONFLICT);
	assign is_cap_wr   = (i_cause == tap_pkg::TAP_CAUSE_CAP_WR);
	assign is_cap_rd   = (i_cause == tap_pkg::TAP_CAUSE_CAP_RD);

	always_comb begin
		o_info = '0;                                                   // see RULE16
		o_info[`TAP_CYC_W-1:0]     = i_cycles;                         // see RULE6
		o_info[`TAP_BIT_INSTR]     = is_instr;                         // see RULE7
		o_info[`TAP_BIT_NONINSTR]  = ~is_instr;                        // see RULE9
		o_info[`TAP_BIT_CONFLICT]  = is_conflict;                      // see RULE10
		o_info[`TAP_BIT_CAP_WR]    = is_cap_wr;                        // see RULE11
		o_info[`TAP_BIT_CAP_RD]    = is_cap_rd;                        // see RULE11
	end

endmodule // tap_abort_classify

// ==== design/tap_gp_counter.sv ====
// one general counter with transactional cycle filters
`include "tap_params.svh"
module tap_gp_counter #(
	parameter int CNT_W      = `TAP_CNT_W,
	parameter bit ALLOW_TXCP = 1'b0
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire tap_pkg::tap_evsel_t i_evsel,
	input  wire logic              i_cycle,
	input  wire logic              i_in_tx,
	input  wire logic              i_tx_begin,
	input  wire logic              i_tx_abort,
	input  wire logic              i_clear,
	output logic [CNT_W-1:0]       o_count
);

	logic             txcp_on;
	logic             tx_filter;
	logic             qual;
	logic [CNT_W-1:0] chkpt_r;
	logic [CNT_W-1:0] count_nxt;

	// checkpointed filter honoured only where allowed
	assign txcp_on   = ALLOW_TXCP & i_evsel.checkpointed_transaction_filter;                   // see RULE2
	assign tx_filter = i_evsel.in_tx | txcp_on;                        // see RULE2
	assign qual      = i_evsel.enable & i_evsel.cycles_event & i_cycle
		& (~tx_filter | i_in_tx);
	// with the checkpointed filter on, an aborted region rolls counts back to its entry value
	assign count_nxt = i_clear ? CNT_W'(0) :
		(txcp_on & i_tx_abort) ? chkpt_r :
		qual ? o_count + CNT_W'(1) : o_count;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_count <= CNT_W'(0);
			chkpt_r <= CNT_W'(0);
		end else begin
			o_count <= count_nxt;
			// save the value before the region's first cycle so a rollback drops all of it
			if (i_tx_begin)
				chkpt_r <= i_clear ? CNT_W'(0) : o_count;
		end
	end

endmodule // tap_gp_counter

// ==== design/tap_params.svh ====
// constants for the transactional abort profiling block
// Behaviour
// RULE1: interrupt inside a region forces an abort
// RULE2: counter two takes both filters; others in-tx only
// RULE3: separate abort sampling events per elision style
// RULE4: record carries abort site pointer
// RULE5: taking a sample never causes an abort
// RULE6: low 32 info bits hold last region cycles
// RULE7: instruction abort sets bit 34 with address
// RULE8: exceptions and page faults count as instruction aborts
// RULE9: non-instruction abort sets bit 35
// RULE10: data conflict sets bit 37 plus bit 35
// RULE11: capacity overflow sets bit 38 or 39
// RULE12: conflict may report any instruction in region
// RULE13: explicit abort operand goes to accumulator register
// RULE14: explicit abort operand also in the record
// RULE15: software codes ff, fe, fd; f0-fc reserved
// RULE16: exactly one of bits 34/35; others clear
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ***********************************
// widths and counts
// ***********************************
`define TAP_IP_W          64
`define TAP_INFO_W        64
`define TAP_CYC_W         32
`define TAP_CNT_W         48
`define TAP_NUM_GP        4
`define TAP_TXCP_CTR      2
`define TAP_CNT_RST       48'h0000_0000_0000

// ***********************************
// abort information field positions
// ***********************************
`define TAP_BIT_INSTR     34
`define TAP_BIT_NONINSTR  35
`define TAP_BIT_CONFLICT  37
`define TAP_BIT_CAP_WR    38
`define TAP_BIT_CAP_RD    39

// ***********************************
// accumulator status layout on abort
// ***********************************
`define TAP_EAX_EXPLICIT  0
`define TAP_EAX_CONFLICT  2
`define TAP_EAX_CAPACITY  3
`define TAP_EAX_CODE_LSB  24
`define TAP_EAX_RST       32'h0000_0000

`endif

// ==== design/tap_pkg.sv ====
// types shared by the transactional abort profiling block
`include "tap_params.svh"
package tap_pkg;

	typedef enum logic [2:0] {
		TAP_CAUSE_INSTR,
		TAP_CAUSE_EXCEPTION,
		TAP_CAUSE_EXPLICIT,
		TAP_CAUSE_CONFLICT,
		TAP_CAUSE_CAP_WR,
		TAP_CAUSE_CAP_RD,
		TAP_CAUSE_INTERRUPT,
		TAP_CAUSE_OTHER
	} tap_cause_t;

	typedef enum logic {
		TAP_KIND_ELISION,
		TAP_KIND_RESTRICTED
	} tap_kind_t;

	typedef enum logic [1:0] {
		TAP_ST_IDLE,
		TAP_ST_IN_TX,
		TAP_ST_KILL
	} tap_state_t;

	typedef struct packed {
		logic enable;
		logic cycles_event;
		logic in_tx;
		logic checkpointed_transaction_filter;
	} tap_evsel_t;

	typedef struct packed {
		logic                   valid;
		tap_kind_t              kind;
		tap_cause_t             cause;
		logic [`TAP_IP_W-1:0]   site_ip;
		logic [`TAP_IP_W-1:0]   return_ip;
		logic [7:0]             xabort_imm;
	} tap_abort_t;

	typedef struct packed {
		tap_kind_t              kind;
		logic [`TAP_IP_W-1:0]   abort_site_pointer;
		logic [`TAP_IP_W-1:0]   return_ip;
		logic [`TAP_INFO_W-1:0] abort_info;
		logic [7:0]             xabort_code;
	} tap_sample_t;

endpackage

// ==== design/tap_top.sv ====
// transactional abort profiling: cycle filters, abort sampling, fallback status
`include "tap_params.svh"
module tap_top #(
	parameter int CNT_W  = `TAP_CNT_W,
	parameter int NUM_GP = `TAP_NUM_GP
) (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_unhalted,
	input  wire logic                          i_tx_active,
	input  wire tap_pkg::tap_kind_t            i_tx_kind,
	input  wire tap_pkg::tap_abort_t           i_abort,
	input  wire logic                          i_irq_pending,
	input  wire tap_pkg::tap_evsel_t [NUM_GP-1:0] i_evsel,
	input  wire logic [NUM_GP-1:0]             i_cnt_clear,
	input  wire logic                          i_fixed_clear,
	input  wire logic                          i_elision_sample_en,
	input  wire logic                          i_restricted_sample_en,
	output logic [CNT_W-1:0]                   o_fixed_cycle_counter_r,
	output logic [NUM_GP-1:0][CNT_W-1:0]       o_gp_count,
	output logic [NUM_GP-1:0]                  o_txcp_refused_r,
	output logic                               o_in_tx_r,
	output logic                               o_tx_abort_req_r,
	output logic                               o_elision_abort_event_r,
	output logic                               o_restricted_tx_abort_event_r,
	output logic                               o_sample_valid_r,
	output tap_pkg::tap_sample_t               o_sample_r,
	output logic                               o_eax_valid_r,
	output logic [31:0]                        o_fallback_eax_r,
	output logic [CNT_W-1:0]                   o_elision_aborts_r,
	output logic [CNT_W-1:0]                   o_restricted_aborts_r
);

	// ***********************************
	// region tracking
	// ***********************************
	tap_pkg::tap_state_t      state_r;
	tap_pkg::tap_state_t      state_nxt;
	tap_pkg::tap_kind_t       kind_r;
	logic [`TAP_CYC_W-1:0]    cycles_r;
	logic [`TAP_CYC_W-1:0]    cycles_nxt;
	logic                     tx_begin;
	logic                     abort_take;
	logic                     irq_kill;
	logic                     commit;
	logic                     cyc_sat;

	assign tx_begin   = (state_r == tap_pkg::TAP_ST_IDLE) & i_tx_active;
	// aborts outside a region are stale reports and are dropped
	assign abort_take = i_abort.valid & (state_r != tap_pkg::TAP_ST_IDLE);
	// an interrupt inside a region must end it with an abort
	assign irq_kill   = (state_r == tap_pkg::TAP_ST_IN_TX) & i_irq_pending
		& ~i_abort.valid;                                              // see RULE1
	assign commit     = (state_r == tap_pkg::TAP_ST_IN_TX) & ~i_tx_active
		& ~i_abort.valid;
	assign cyc_sat    = &cycles_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			tap_pkg::TAP_ST_IDLE: begin
				if (i_tx_active)
					state_nxt = tap_pkg::TAP_ST_IN_TX;
			end
			tap_pkg::TAP_ST_IN_TX: begin
				if (abort_take | commit)
					state_nxt = tap_pkg::TAP_ST_IDLE;
				else if (irq_kill)
					state_nxt = tap_pkg::TAP_ST_KILL;              // see RULE1
			end
			tap_pkg::TAP_ST_KILL: begin
				if (abort_take)
					state_nxt = tap_pkg::TAP_ST_IDLE;
			end
		endcase
	end

	// cycles of the current region, set to one on entry, saturating
	assign cycles_nxt = tx_begin ? `TAP_CYC_W'(1) :
		((state_r != tap_pkg::TAP_ST_IDLE) & ~cyc_sat) ?
		cycles_r + `TAP_CYC_W'(1) : cycles_r;                         // see RULE6

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_r  <= tap_pkg::TAP_ST_IDLE;
			cycles_r <= '0;
			kind_r   <= tap_pkg::TAP_KIND_ELISION;
		end else begin
			state_r  <= state_nxt;
			cycles_r <= cycles_nxt;
			if (tx_begin)
				kind_r <= i_tx_kind;
		end
	end

	// request held until the core reports the abort; sampling never drives it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_tx_abort_req_r <= 1'b0;
			o_in_tx_r        <= 1'b0;
		end else begin
			o_tx_abort_req_r <= (state_nxt == tap_pkg::TAP_ST_KILL);   // see RULE1 RULE5
			o_in_tx_r        <= (state_nxt != tap_pkg::TAP_ST_IDLE);
		end
	end

	// ***********************************
	// cycle counters
	// ***********************************
	logic [CNT_W-1:0] fixed_nxt;

	assign fixed_nxt = i_fixed_clear ? CNT_W'(0) :
		i_unhalted ? o_fixed_cycle_counter_r + CNT_W'(1) :
		o_fixed_cycle_counter_r;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n)
			o_fixed_cycle_counter_r <= `TAP_CNT_RST;
		else
			o_fixed_cycle_counter_r <= fixed_nxt;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_GP; g++) begin : g_gp
			localparam bit TXCP_OK = (g == `TAP_TXCP_CTR);
			tap_gp_counter #(
				.CNT_W      (CNT_W),
				.ALLOW_TXCP (TXCP_OK)                                  // see RULE2
			) u_cnt (
				.i_clk_sys  (i_clk_sys),
				.i_rst_n    (i_rst_n),
				.i_evsel    (i_evsel[g]),
				.i_cycle    (i_unhalted),
				.i_in_tx    (i_tx_active),
				.i_tx_begin (tx_begin),
				.i_tx_abort (abort_take),
				.i_clear    (i_cnt_clear[g]),
				.o_count    (o_gp_count[g])
			);
			// status: a checkpoint filter asked of a counter that ignores it
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n)
					o_txcp_refused_r[g] <= 1'b0;
				else
					o_txcp_refused_r[g] <= i_evsel[g].checkpointed_transaction_filter & ~TXCP_OK; // see RULE2
			end
		end
	endgenerate

	// ***********************************
	// abort events and precise samples
	// ***********************************
	logic [`TAP_INFO_W-1:0] info;
	tap_pkg::tap_kind_t     abort_kind;
	logic                   is_elision;
	logic                   is_restricted;
	logic                   sample_fire;
	tap_pkg::tap_sample_t   sample_nxt;

	tap_abort_classify u_class (
		.i_cause  (i_abort.cause),
		.i_cycles (cycles_r),
		.o_info   (info)
	);

	assign abort_kind    = kind_r;
	assign is_elision    = abort_take & (abort_kind == tap_pkg::TAP_KIND_ELISION);
	assign is_restricted = abort_take & (abort_kind == tap_pkg::TAP_KIND_RESTRICTED);
	assign sample_fire   = (is_elision & i_elision_sample_en)
		| (is_restricted & i_restricted_sample_en);                   // see RULE3

	// site pointer is whatever instruction the core blamed, even for conflicts
	assign sample_nxt.kind               = abort_kind;
	assign sample_nxt.abort_site_pointer = i_abort.site_ip;            // see RULE4 RULE12
	assign sample_nxt.return_ip          = i_abort.return_ip;
	assign sample_nxt.abort_info         = info;                       // see RULE6
	assign sample_nxt.xabort_code        = (is_restricted
		& (i_abort.cause == tap_pkg::TAP_CAUSE_EXPLICIT)) ?
		i_abort.xabort_imm : 8'h00;                                    // see RULE14

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_elision_abort_event_r       <= 1'b0;
			o_restricted_tx_abort_event_r <= 1'b0;
			o_sample_valid_r              <= 1'b0;
			o_sample_r                    <= '0;
		end else begin
			o_elision_abort_event_r       <= is_elision;               // see RULE3
			o_restricted_tx_abort_event_r <= is_restricted;            // see RULE3
			o_sample_valid_r              <= sample_fire;
			if (sample_fire)
				o_sample_r <= sample_nxt;
		end
	end

	// per-style abort totals
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_elision_aborts_r    <= `TAP_CNT_RST;
			o_restricted_aborts_r <= `TAP_CNT_RST;
		end else begin
			if (is_elision)
				o_elision_aborts_r <= o_elision_aborts_r + CNT_W'(1);
			if (is_restricted)
				o_restricted_aborts_r <= o_restricted_aborts_r + CNT_W'(1);
		end
	end

	// ***********************************
	// fallback handler status
	// ***********************************
	logic [31:0] eax_nxt;
	logic        cap_cause;

	assign cap_cause = (i_abort.cause == tap_pkg::TAP_CAUSE_CAP_WR)
		| (i_abort.cause == tap_pkg::TAP_CAUSE_CAP_RD);

	// software code convention (ff/fe/fd, f0-fc reserved) passes through untouched
	always_comb begin
		eax_nxt = `TAP_EAX_RST;
		if (i_abort.cause == tap_pkg::TAP_CAUSE_EXPLICIT) begin
			eax_nxt[`TAP_EAX_EXPLICIT] = 1'b1;
			eax_nxt[`TAP_EAX_CODE_LSB +: 8] = i_abort.xabort_imm;    // see RULE13 RULE15
		end
		eax_nxt[`TAP_EAX_CONFLICT] = (i_abort.cause == tap_pkg::TAP_CAUSE_CONFLICT);
		eax_nxt[`TAP_EAX_CAPACITY] = cap_cause;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_eax_valid_r    <= 1'b0;
			o_fallback_eax_r <= `TAP_EAX_RST;
		end else begin
			o_eax_valid_r <= is_restricted;
			if (is_restricted)
				o_fallback_eax_r <= eax_nxt;                           // see RULE13
		end
	end

endmodule // tap_top

// ==== sim/tap_top_checker.sv ====
// assertions on the ports of the transactional abort profiling top
module tap_top_checker #(
	parameter int NUM_GP = 4
) (
	input wire logic                             i_clk_sys,
	input wire logic                             i_rst_n,
	input wire logic                             i_tx_active,
	input wire tap_pkg::tap_abort_t              i_abort,
	input wire logic                             i_irq_pending,
	input wire tap_pkg::tap_evsel_t [NUM_GP-1:0] i_evsel,
	input wire logic [NUM_GP-1:0]                o_txcp_refused_r,
	input wire logic                             o_in_tx_r,
	input wire logic                             o_tx_abort_req_r,
	input wire logic                             o_elision_abort_event_r,
	input wire logic                             o_restricted_tx_abort_event_r,
	input wire logic                             o_sample_valid_r,
	input wire tap_pkg::tap_sample_t             o_sample_r,
	input wire logic                             o_eax_valid_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	wire [63:0] info_w = o_sample_r.abort_info;

	// ************************
	// abort handshake
	// ************************
	sequence s_kill_asked;
		o_in_tx_r && i_tx_active && i_irq_pending && !i_abort.valid && !o_tx_abort_req_r;
	endsequence
	sequence s_abort_taken;
		o_in_tx_r && i_abort.valid;
	endsequence
	a_irq_kill_req: assert property (s_kill_asked |=> o_tx_abort_req_r)
		else $error("interrupt in region did not request abort");
	a_req_held: assert property (o_tx_abort_req_r && !i_abort.valid |=> o_tx_abort_req_r)
		else $error("abort request dropped early");
	a_req_drops: assert property (s_abort_taken ##0 o_tx_abort_req_r |=> !o_tx_abort_req_r)
		else $error("abort request held after abort");
	a_one_event: assert property (s_abort_taken |=> o_elision_abort_event_r != o_restricted_tx_abort_event_r)
		else $error("abort did not give exactly one event");
	a_no_stray_event: assert property (!o_in_tx_r |=> !(o_elision_abort_event_r || o_restricted_tx_abort_event_r || o_eax_valid_r))
		else $error("event outside a region");

	// ************************
	// record contents
	// ************************
	a_flags_exclusive: assert property (o_sample_valid_r |-> (info_w[34] ^ info_w[35]) && info_w[63:40] == 24'h0 && info_w[36] == 1'b0 && info_w[33:32] == 2'h0)
		else $error("abort flags not exclusive");
	a_conflict_noninstr: assert property (o_sample_valid_r && info_w[37] |-> info_w[35])
		else $error("conflict without non-instruction flag");
	a_cap_noninstr: assert property (o_sample_valid_r && (info_w[38] || info_w[39]) |-> info_w[35] && !(info_w[38] && info_w[39]))
		else $error("capacity flags wrong");
	a_no_self_abort: assert property (o_sample_valid_r |-> !o_tx_abort_req_r)
		else $error("sampling raised an abort request");
	a_code_restricted: assert property (o_sample_valid_r && o_sample_r.kind == tap_pkg::TAP_KIND_ELISION |-> o_sample_r.xabort_code == 8'h00)
		else $error("operand code on elision record");
	a_eax_restricted: assert property (o_eax_valid_r |-> o_restricted_tx_abort_event_r)
		else $error("accumulator update without restricted abort");
	a_txcp_refused: assert property (i_evsel[3].checkpointed_transaction_filter |=> o_txcp_refused_r[3])
		else $error("checkpoint filter accepted on counter 3");
	a_txcp_kept: assert property (1'b1 |-> !o_txcp_refused_r[2])
		else $error("checkpoint filter refused on counter 2");
endmodule // tap_top_checker

// ==== sim/test_tap_top.sv ====
// self-checking bench for the transactional abort profiling top
`include "tap_params.svh"
module test_tap_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys, i_rst_n, i_unhalted, i_tx_active, i_irq_pending, i_fixed_clear;
	logic i_elision_sample_en, i_restricted_sample_en;
	tap_pkg::tap_kind_t i_tx_kind;
	tap_pkg::tap_abort_t i_abort;
	tap_pkg::tap_evsel_t [3:0] i_evsel;
	logic [3:0] i_cnt_clear, o_txcp_refused_r;
	logic [47:0] o_fixed_cycle_counter_r, o_elision_aborts_r, o_restricted_aborts_r;
	logic [3:0][47:0] o_gp_count;
	logic o_in_tx_r, o_tx_abort_req_r, o_elision_abort_event_r, o_restricted_tx_abort_event_r;
	logic o_sample_valid_r, o_eax_valid_r;
	tap_pkg::tap_sample_t o_sample_r;
	logic [31:0] o_fallback_eax_r;
	int err_total = 0;
	int checks_done = 0;
	int n_edge = 0;

	tap_top DUT (.i_clk_sys, .i_rst_n, .i_unhalted, .i_tx_active, .i_tx_kind, .i_abort,
		.i_irq_pending, .i_evsel, .i_cnt_clear, .i_fixed_clear, .i_elision_sample_en,
		.i_restricted_sample_en, .o_fixed_cycle_counter_r, .o_gp_count, .o_txcp_refused_r,
		.o_in_tx_r, .o_tx_abort_req_r, .o_elision_abort_event_r, .o_restricted_tx_abort_event_r,
		.o_sample_valid_r, .o_sample_r, .o_eax_valid_r, .o_fallback_eax_r, .o_elision_aborts_r,
		.o_restricted_aborts_r);

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk_sys);
		n_edge += n;
	endtask

	// ************************
	// one region of n cycles ended by an abort, record checked
	// ************************
	task automatic run_region(input tap_pkg::tap_kind_t k, input tap_pkg::tap_cause_t c,
		input logic [7:0] imm, input int n, input logic irq);
		logic [63:0] info;
		logic [31:0] eax;
		logic        rt;
		logic        en;
		rt = (k == tap_pkg::TAP_KIND_RESTRICTED);
		en = rt ? i_restricted_sample_en : i_elision_sample_en;
		info = {32'h0, n[31:0]};
		info[`TAP_BIT_INSTR] = c inside {tap_pkg::TAP_CAUSE_INSTR, tap_pkg::TAP_CAUSE_EXCEPTION,
			tap_pkg::TAP_CAUSE_EXPLICIT};
		info[`TAP_BIT_NONINSTR] = !info[`TAP_BIT_INSTR];
		info[`TAP_BIT_CONFLICT] = (c == tap_pkg::TAP_CAUSE_CONFLICT);
		info[`TAP_BIT_CAP_WR] = (c == tap_pkg::TAP_CAUSE_CAP_WR);
		info[`TAP_BIT_CAP_RD] = (c == tap_pkg::TAP_CAUSE_CAP_RD);
		eax = 32'h0;
		case (c)
			tap_pkg::TAP_CAUSE_EXPLICIT: eax = {imm, 24'h1};
			tap_pkg::TAP_CAUSE_CONFLICT: eax = 32'h4;
			tap_pkg::TAP_CAUSE_CAP_WR, tap_pkg::TAP_CAUSE_CAP_RD: eax = 32'h8;
			default: eax = 32'h0;
		endcase
		tick(1);
		i_tx_kind = k;
		i_tx_active = 1'b1;
		i_irq_pending = irq;
		tick(n);
		cmp_val(o_tx_abort_req_r, irq);
		cmp_val(o_in_tx_r, 1'b1);
		i_abort = '{1'b1, k, c, 64'h1000 + 64'(n), 64'h4000, imm};
		tick(1);
		cmp_val(o_elision_abort_event_r, !rt);
		cmp_val(o_restricted_tx_abort_event_r, rt);
		cmp_val(o_tx_abort_req_r, 1'b0);
		cmp_val(o_in_tx_r, 1'b0);
		cmp_val(o_sample_valid_r, en);
		if (en) begin
			cmp_val(o_sample_r.abort_info, info);
			cmp_val(o_sample_r.abort_site_pointer, 64'h1000 + 64'(n));
			cmp_val(o_sample_r.return_ip, 64'h4000);
			cmp_val(o_sample_r.kind, k);
			cmp_val(o_sample_r.xabort_code, (rt && c == tap_pkg::TAP_CAUSE_EXPLICIT) ? imm : 8'h00);
		end
		cmp_val(o_eax_valid_r, rt);
		if (rt) begin
			cmp_val(o_fallback_eax_r, eax);
		end
		i_abort.valid = 1'b0;
		i_tx_active = 1'b0;
		i_irq_pending = 1'b0;
	endtask

	task automatic end_of_test();
		$display("counts: %0d checks, %0d mismatches", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		end_of_test();
	end

	// ************************
	// tests
	// ************************
	initial begin
		{i_rst_n, i_unhalted, i_tx_active, i_irq_pending, i_fixed_clear} = 5'h0;
		{i_elision_sample_en, i_restricted_sample_en, i_cnt_clear} = 6'h0;
		i_tx_kind = tap_pkg::TAP_KIND_ELISION;
		i_abort = '0;
		i_evsel = '0;
		repeat (2) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		cmp_val(o_in_tx_r, 1'b0);
		cmp_val(o_fallback_eax_r, 32'h0);
		cmp_val(o_gp_count[2], 48'h0);
		$display("test reset done");
		i_evsel = {4'hf, 4'hf, 4'hc, 4'he};
		{i_unhalted, i_elision_sample_en, i_restricted_sample_en} = 3'h7;
		{i_cnt_clear, i_fixed_clear} = 5'h1f;
		tick(1);
		{i_cnt_clear, i_fixed_clear} = 5'h0;
		n_edge = 0;
		i_tx_active = 1'b1;
		tick(3);
		i_tx_active = 1'b0;
		run_region(tap_pkg::TAP_KIND_RESTRICTED, tap_pkg::TAP_CAUSE_CONFLICT, 8'h00, 5, 1'b0);
		cmp_val(o_gp_count[0], 48'h9);
		cmp_val(o_gp_count[2], 48'h3);
		cmp_val(o_gp_count[3], 48'h9);
		cmp_val(o_gp_count[1], 48'(n_edge));
		cmp_val(o_fixed_cycle_counter_r, 48'(n_edge));
		cmp_val(o_txcp_refused_r, 4'h8);
		$display("test counters done");
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 8; c++) begin
				i_elision_sample_en = (c != 7);
				run_region(tap_pkg::tap_kind_t'(k[0]), tap_pkg::tap_cause_t'(c[2:0]),
					8'hff - 8'(c % 3),
					c + 1, c == 6);
			end
		end
		cmp_val(o_elision_aborts_r, 48'h8);
		cmp_val(o_restricted_aborts_r, 48'h9);
		$display("test causes done");
		end_of_test();
	end
endmodule // test_tap_top

bind tap_top tap_top_checker #(.NUM_GP(NUM_GP)) u_chk (.i_clk_sys, .i_rst_n, .i_tx_active,
	.i_abort, .i_irq_pending, .i_evsel, .o_txcp_refused_r, .o_in_tx_r, .o_tx_abort_req_r,
	.o_elision_abort_event_r, .o_restricted_tx_abort_event_r, .o_sample_valid_r, .o_sample_r,
	.o_eax_valid_r);
